// File: shared/jsr_pkg.sv
// Contract
// - Status 0x01 bit 7 follows line-level load on tip contact.
// - Status 0x01 bit 6 follows line-level load on first ring contact.
// - Bits 5 and 4 report headphone load on tip and first ring.
// - Button press or release sets flag bit 2 and latches button code.
// - Reading address 0x01 clears the button flag.
// - Button flag sets only after debounce plus delay time.
// - Outside sleep, bit 1 shows whether the button or hook event was press or release.
// - On release, bit 1 clears 0.5 ms after the flag sets.
// - Status 0x02 bit 3 shows device reset since last read.
// - Two-bit common-contact field: none, second ring, sleeve, both.
// - Interrupt line goes low when an enabled status bit is set.
// - Mask bit 7 enables jack found, bit 6 configuration done.
// - Mask bit 5 enables slew done, bit 3 microphone; masks reset to 0.
// - Hook flag sets after bias low for debounce plus delay (debounce only in sleep); read clears.
// - Mask bit 1 enables the hook-switch interrupt.
package jsr_pkg;

    localparam logic [7:0] ADDR_UPPER_STATUS  = 8'h00;
    localparam logic [7:0] ADDR_LOAD_BUTTON   = 8'h01;
    localparam logic [7:0] ADDR_RESET_COMMON  = 8'h02;
    localparam logic [7:0] ADDR_SPARE_THREE   = 8'h03;
    localparam logic [7:0] ADDR_IRQ_EN_FIRST  = 8'h04;

    localparam int BIT_LINE_TIP      = 7;
    localparam int BIT_LINE_FIRST_RING_CONTACT    = 6;
    localparam int BIT_TIP_PHONE     = 5;
    localparam int BIT_FIRST_RING_CONTACT_PHONE   = 4;
    localparam int BIT_BUTTON_EVENT  = 2;
    localparam int BIT_PRESS         = 1;
    localparam int BIT_RESET_SEEN    = 3;
    localparam int BIT_JACK_FOUND    = 7;
    localparam int BIT_CONFIG_DONE   = 6;
    localparam int BIT_SLEW_DONE     = 5;
    localparam int BIT_MIC_PRESENT   = 3;
    localparam int BIT_JACK_SWITCH   = 2;
    localparam int BIT_HOOK_SWITCH   = 1;

    localparam logic [7:0] SPARE_RESET       = 8'h00;
    localparam logic [7:0] IRQ_EN_RESET      = 8'h00;
    localparam logic [7:0] IRQ_EN_WRITE_MASK = 8'hEE;
    localparam logic       RESET_SEEN_RESET  = 1'b1;

    localparam logic [1:0] COMMON_NONE   = 2'h0;
    localparam logic [1:0] COMMON_SECOND_RING_CONTACT  = 2'h1;
    localparam logic [1:0] COMMON_SLEEVE = 2'h2;
    localparam logic [1:0] COMMON_BOTH   = 2'h3;

    // Bus address of the register port; the value is arbitrary.
    localparam logic [6:0] DEV_ADDR = 7'h2A;

    localparam int CLK_PERIOD_NS    = 10;
    localparam int RELEASE_DELAY_NS = 500000;
    localparam int RELEASE_CYCLES   = RELEASE_DELAY_NS / CLK_PERIOD_NS;
    localparam int TIMER_W          = 16;
    localparam int QUAL_W           = 9;
    localparam int CODE_W           = 8;

    typedef struct packed {
        logic              line_tip;
        logic              line_first_ring_contact;
        logic              tip_phone_load_seen;
        logic              first_ring_contact_phone_load_seen;
        logic              jack_found;
        logic              config_done;
        logic              slew_done;
        logic              mic_present;
        logic              jack_switch;
        logic              button_down;
        logic              bias_low;
        logic              sleep;
        logic [1:0]        common_loc;
        logic [CODE_W-1:0] button_raw_code;
    } jsr_detect_t;

    typedef enum logic [2:0] {
        I2C_IDLE, I2C_ADDR, I2C_ACK, I2C_REG, I2C_WR, I2C_RD, I2C_RACK
    } jsr_i2c_st_t;

    typedef struct packed {
        logic              level;
        logic [QUAL_W-1:0] cnt;
        logic              event_p;
    } jsr_qual_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic value;
    } jsr_sync_t;

endpackage : jsr_pkg

// File: logic/jsr_sync.sv
module jsr_sync
    import jsr_pkg::*;
#(
    parameter logic IDLE_LEVEL = 1'b1
) (
    input  wire logic i_sys_clk,
    input  wire logic i_reset,
    input  wire logic i_pin,
    output logic      o_level
);
    jsr_sync_t q;
    jsr_sync_t d;

    // A change is taken only once the second and third stages agree.
    always_comb begin
        d    = q;
        d.s1 = i_pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.value = q.s3;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            q <= {IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL};
        end else begin
            q <= d;
        end
    end

    assign o_level = q.value;

endmodule : jsr_sync

// File: logic/jsr_key_qual.sv
module jsr_key_qual
    import jsr_pkg::*;
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset,
    input  wire logic              i_level,
    input  wire logic              i_tick,
    input  wire logic [QUAL_W-1:0] i_target,
    output logic                   o_level,
    output logic                   o_event
);
    jsr_qual_t q;
    jsr_qual_t d;

    // A new level must hold until the target number of ticks has been counted before it is accepted.
    always_comb begin
        d         = q;
        d.event_p = 1'b0;
        if (i_level != q.level) begin
            if (q.cnt >= i_target) begin
                d.level   = i_level;
                d.cnt     = '0;
                d.event_p = 1'b1;
            end else if (i_tick) begin
                d.cnt = q.cnt + QUAL_W'(1);
            end
        end else begin
            d.cnt = '0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_level = q.level;
    assign o_event = q.event_p;

endmodule : jsr_key_qual

// File: logic/jsr_regs.sv
module jsr_regs
    import jsr_pkg::*;
#(
    parameter int P_RELEASE_CYCLES = RELEASE_CYCLES
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset,
    input  wire logic              i_scl,
    input  wire logic              i_sda,
    output logic                   o_sda_out,
    output logic                   o_sda_oe,
    input  wire jsr_detect_t       i_detect,
    input  wire logic [7:0]        i_debounce_ticks,
    input  wire logic [7:0]        i_delay_ticks,
    input  wire logic              i_button_irq_enable,
    output logic                   o_irq_n,
    output logic [CODE_W-1:0]      o_button_code
);
    localparam logic [TIMER_W-1:0] RELEASE_LAST = TIMER_W'(P_RELEASE_CYCLES - 1);

    typedef struct packed {
        logic               scl_p;
        logic               sda_p;
        jsr_i2c_st_t        st;
        jsr_i2c_st_t        nxt;
        logic [7:0]         shift;
        logic [3:0]         bit_cnt;
        logic [7:0]         ptr;
        logic               more;
        logic               sda_oe;
        logic               sda_out;
        logic               irq_n;
        logic               button_flag;
        logic               hook_switch_flag;
        logic               press;
        logic               reset_seen;
        logic               rel_busy;
        logic [TIMER_W-1:0] rel_cnt;
        logic [TIMER_W-1:0] tick_cnt;
        logic               tick;
        logic [7:0]         spare;
        logic [7:0]         irq_enable;
        logic [CODE_W-1:0]  button_code;
    } jsr_regs_t;

    jsr_regs_t q;
    jsr_regs_t d;

    logic scl_s;
    logic sda_s;
    logic btn_level;
    logic btn_event;
    logic hook_level;
    logic hook_event;

    function automatic logic [QUAL_W-1:0] qual_target(input logic [7:0] deb,
                                                      input logic [7:0] dly,
                                                      input logic       skip_delay);
        logic [QUAL_W-1:0] sum;
        sum = {1'b0, deb};
        if (!skip_delay) begin
            sum = sum + {1'b0, dly};
        end
        return sum;
    endfunction : qual_target

    jsr_sync #(.IDLE_LEVEL(1'b1)) u_sync_scl (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_pin     (i_scl),
        .o_level   (scl_s)
    );

    jsr_sync #(.IDLE_LEVEL(1'b1)) u_sync_sda (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_pin     (i_sda),
        .o_level   (sda_s)
    );

    // The button waits for debounce plus delay before it counts.
    jsr_key_qual u_qual_button (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_level   (i_detect.button_down),
        .i_tick    (q.tick),
        .i_target  (qual_target(i_debounce_ticks, i_delay_ticks, 1'b0)),
        .o_level   (btn_level),
        .o_event   (btn_event)
    );

    // In sleep the hook switch skips the delay part of its wait.
    jsr_key_qual u_qual_hook (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_level   (i_detect.bias_low),
        .i_tick    (q.tick),
        .i_target  (qual_target(i_debounce_ticks, i_delay_ticks, i_detect.sleep)),
        .o_level   (hook_level),
        .o_event   (hook_event)
    );

    logic [7:0] upper_byte;
    logic [7:0] load_byte;
    logic [7:0] common_byte;
    logic [7:0] rd_data;
    logic       rd_en;
    logic       wr_en;
    logic       start_cond;
    logic       stop_cond;
    logic       scl_rise;
    logic       scl_fall;
    logic       irq_cause;

    always_comb begin
        upper_byte                   = 8'h00;
        upper_byte[BIT_JACK_FOUND]   = i_detect.jack_found;
        upper_byte[BIT_CONFIG_DONE]  = i_detect.config_done;
        upper_byte[BIT_SLEW_DONE]    = i_detect.slew_done;
        upper_byte[BIT_MIC_PRESENT]  = i_detect.mic_present;
        upper_byte[BIT_JACK_SWITCH]  = i_detect.jack_switch;
        upper_byte[BIT_HOOK_SWITCH]  = q.hook_switch_flag;

        load_byte                    = 8'h00;
        load_byte[BIT_LINE_TIP]      = i_detect.line_tip;
        load_byte[BIT_LINE_FIRST_RING_CONTACT]    = i_detect.line_first_ring_contact;
        load_byte[BIT_TIP_PHONE]     = i_detect.tip_phone_load_seen;
        load_byte[BIT_FIRST_RING_CONTACT_PHONE]   = i_detect.first_ring_contact_phone_load_seen;
        load_byte[BIT_BUTTON_EVENT]  = q.button_flag;
        load_byte[BIT_PRESS]         = q.press;

        common_byte                  = 8'h00;
        common_byte[BIT_RESET_SEEN]  = q.reset_seen;
        common_byte[1:0]             = i_detect.common_loc;

        case (q.ptr)
            ADDR_UPPER_STATUS: rd_data = upper_byte;
            ADDR_LOAD_BUTTON:  rd_data = load_byte;
            ADDR_RESET_COMMON: rd_data = common_byte;
            ADDR_SPARE_THREE:  rd_data = q.spare;
            ADDR_IRQ_EN_FIRST: rd_data = q.irq_enable;
            default:           rd_data = 8'h00;
        endcase
    end

    always_comb begin
        d          = q;
        rd_en      = 1'b0;
        wr_en      = 1'b0;
        d.scl_p    = scl_s;
        d.sda_p    = sda_s;
        d.sda_out  = 1'b0;
        start_cond = scl_s && q.scl_p && q.sda_p && !sda_s;
        stop_cond  = scl_s && q.scl_p && !q.sda_p && sda_s;
        scl_rise   = scl_s && !q.scl_p;
        scl_fall   = !scl_s && q.scl_p;

        // The half-millisecond tick paces debounce and delay; release runs its own counter of the same length.
        d.tick = 1'b0;
        if (q.tick_cnt == RELEASE_LAST) begin
            d.tick_cnt = '0;
            d.tick     = 1'b1;
        end else begin
            d.tick_cnt = q.tick_cnt + TIMER_W'(1);
        end

        if (start_cond) begin
            d.st      = I2C_ADDR;
            d.bit_cnt = 4'h0;
            d.sda_oe  = 1'b0;
        end else if (stop_cond) begin
            d.st     = I2C_IDLE;
            d.sda_oe = 1'b0;
        end else if (scl_rise) begin
            case (q.st)
                I2C_ADDR, I2C_REG, I2C_WR: begin
                    d.shift   = {q.shift[6:0], sda_s};
                    d.bit_cnt = q.bit_cnt + 4'h1;
                end
                I2C_RACK: d.more = !sda_s;
                default:  ;
            endcase
        end else if (scl_fall) begin
            case (q.st)
                I2C_ADDR: begin
                    if (q.bit_cnt == 4'h8) begin
                        if (q.shift[7:1] == DEV_ADDR) begin
                            d.sda_oe = 1'b1;
                            d.nxt    = q.shift[0] ? I2C_RD : I2C_REG;
                            d.st     = I2C_ACK;
                        end else begin
                            d.st = I2C_IDLE;
                        end
                    end
                end
                I2C_REG: begin
                    if (q.bit_cnt == 4'h8) begin
                        d.ptr    = q.shift;
                        d.sda_oe = 1'b1;
                        d.nxt    = I2C_WR;
                        d.st     = I2C_ACK;
                    end
                end
                I2C_WR: begin
                    if (q.bit_cnt == 4'h8) begin
                        wr_en    = 1'b1;
                        d.ptr    = q.ptr + 8'h01;
                        d.sda_oe = 1'b1;
                        d.nxt    = I2C_WR;
                        d.st     = I2C_ACK;
                    end
                end
                I2C_ACK: begin
                    d.bit_cnt = 4'h0;
                    if (q.nxt == I2C_RD) begin
                        rd_en = 1'b1;
                    end else begin
                        d.sda_oe = 1'b0;
                        d.st     = q.nxt;
                    end
                end
                I2C_RD: begin
                    if (q.bit_cnt == 4'h7) begin
                        d.sda_oe = 1'b0;
                        d.st     = I2C_RACK;
                    end else begin
                        d.shift   = {q.shift[6:0], 1'b0};
                        d.sda_oe  = !q.shift[6];
                        d.bit_cnt = q.bit_cnt + 4'h1;
                    end
                end
                I2C_RACK: begin
                    if (q.more) begin
                        rd_en = 1'b1;
                    end else begin
                        d.st = I2C_IDLE;
                    end
                end
                default: d.st = I2C_IDLE;
            endcase
        end

        if (rd_en) begin
            d.shift   = rd_data;
            d.sda_oe  = !rd_data[7];
            d.bit_cnt = 4'h0;
            d.st      = I2C_RD;
            d.ptr     = q.ptr + 8'h01;
            case (q.ptr)
                ADDR_UPPER_STATUS: d.hook_switch_flag = 1'b0;
                ADDR_LOAD_BUTTON:  d.button_flag      = 1'b0;
                ADDR_RESET_COMMON: d.reset_seen       = 1'b0;
                default:           ;
            endcase
        end

        // Only the spare and enable registers take writes; status writes are dropped.
        if (wr_en) begin
            case (q.ptr)
                ADDR_SPARE_THREE:  d.spare      = q.shift;
                ADDR_IRQ_EN_FIRST: d.irq_enable = q.shift & IRQ_EN_WRITE_MASK;
                default:           ;
            endcase
        end

        if (q.rel_busy) begin
            if (q.rel_cnt == RELEASE_LAST) begin
                d.press    = 1'b0;
                d.rel_busy = 1'b0;
            end else begin
                d.rel_cnt = q.rel_cnt + TIMER_W'(1);
            end
        end

        // Events are applied after the read clears so that a set always wins.
        if (btn_event) begin
            d.button_flag = 1'b1;
            d.button_code = i_detect.button_raw_code;
        end
        if (hook_event && hook_level) begin
            d.hook_switch_flag = 1'b1;
        end
        if ((btn_event && btn_level) || (hook_event && hook_level)) begin
            d.rel_busy = 1'b0;
            if (!i_detect.sleep) begin
                d.press = 1'b1;
            end
        end else if ((btn_event && !btn_level) || (hook_event && !hook_level)) begin
            d.rel_busy = q.press;
            d.rel_cnt  = '0;
        end

        irq_cause = |(q.irq_enable & upper_byte)
                  | (q.button_flag & i_button_irq_enable)
                  | q.reset_seen;
        d.irq_n   = !irq_cause;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            q            <= '0;
            q.scl_p      <= 1'b1;
            q.sda_p      <= 1'b1;
            q.st         <= I2C_IDLE;
            q.nxt        <= I2C_IDLE;
            q.irq_n      <= 1'b1;
            q.reset_seen <= RESET_SEEN_RESET;
            q.spare      <= SPARE_RESET;
            q.irq_enable <= IRQ_EN_RESET;
        end else begin
            q <= d;
        end
    end

    assign o_sda_out     = q.sda_out;
    assign o_sda_oe      = q.sda_oe;
    assign o_irq_n       = q.irq_n;
    assign o_button_code = q.button_code;

endmodule : jsr_regs

// File: tb/jsr_regs_assertions.sv
module jsr_regs_checker
    import jsr_pkg::*;
#(
    parameter int P_RELEASE_CYCLES = RELEASE_CYCLES
) (
    input wire logic              i_sys_clk,
    input wire logic              i_reset,
    input wire logic              i_scl,
    input wire logic              i_sda,
    input wire logic              o_sda_out,
    input wire logic              o_sda_oe,
    input wire jsr_detect_t       i_detect,
    input wire logic [7:0]        i_debounce_ticks,
    input wire logic [7:0]        i_delay_ticks,
    input wire logic              i_button_irq_enable,
    input wire logic              o_irq_n,
    input wire logic [CODE_W-1:0] o_button_code
);
    int         stable_cnt;
    int         need;
    logic [7:0] quiet_cnt;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    assign need = (int'(i_debounce_ticks) + int'(i_delay_ticks) - 1) * P_RELEASE_CYCLES;

    // The tick phase is free running, so only all but one tick of the wait is guaranteed.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || $changed(i_detect.button_down)) begin
            stable_cnt <= 0;
        end else if (stable_cnt != 32'h7FFF_FFFF) begin
            stable_cnt <= stable_cnt + 1;
        end
    end

    // The line may only be released shortly after something outside has moved.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || $changed(i_scl) || $changed(i_detect) || $changed(i_button_irq_enable)) begin
            quiet_cnt <= 8'h00;
        end else if (quiet_cnt != 8'hFF) begin
            quiet_cnt <= quiet_cnt + 8'h01;
        end
    end

    property p_reset_values;
        $fell(i_reset) |-> o_irq_n && !o_sda_oe && !o_sda_out && o_button_code == '0;
    endproperty
    property p_reset_irq;
        $fell(i_reset) |-> ##[1:2] !o_irq_n;
    endproperty
    property p_reset_irq_holds;
        $fell(i_reset) ##2 1'b1 |-> !o_irq_n [*8];
    endproperty
    property p_code_source;
        $changed(o_button_code) |-> o_button_code == $past(i_detect.button_raw_code);
    endproperty
    property p_code_debounced;
        $changed(o_button_code) |-> stable_cnt >= need;
    endproperty
    property p_code_irq;
        $changed(o_button_code) && i_button_irq_enable |-> ##[0:2] !o_irq_n;
    endproperty
    property p_irq_release;
        $rose(o_irq_n) |-> quiet_cnt < 8'h10;
    endproperty
    property p_drive_on_low;
        $changed(o_sda_oe) |-> !i_scl;
    endproperty

    a_reset_values: assert property (p_reset_values)
        else $error("outputs not at reset values after reset");
    a_reset_irq: assert property (p_reset_irq)
        else $error("no interrupt after reset release");
    a_reset_irq_holds: assert property (p_reset_irq_holds)
        else $error("reset interrupt dropped without a read");
    a_code_source: assert property (p_code_source)
        else $error("button code not taken from raw code");
    a_code_debounced: assert property (p_code_debounced)
        else $error("button event accepted too early");
    a_code_irq: assert property (p_code_irq)
        else $error("enabled button event gave no interrupt");
    a_irq_release: assert property (p_irq_release)
        else $error("interrupt released without a cause");
    a_drive_on_low: assert property (p_drive_on_low)
        else $error("data drive changed while clock high");

    cover property ($fell(o_irq_n));
    cover property ($changed(o_button_code));
    cover property ($rose(o_sda_oe));
    cover property (i_scl && $fell(i_sda));
endmodule : jsr_regs_checker

bind jsr_regs jsr_regs_checker #(.P_RELEASE_CYCLES(P_RELEASE_CYCLES)) u_jsr_regs_checker (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_detect(i_detect),
    .i_debounce_ticks(i_debounce_ticks), .i_delay_ticks(i_delay_ticks),
    .i_button_irq_enable(i_button_irq_enable), .o_irq_n(o_irq_n),
    .o_button_code(o_button_code)
);

// File: tb/jsr_host_model.sv
module jsr_host_model
    import jsr_pkg::*;
(
    input  wire logic i_sys_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    // Eight clocks a phase keeps each level well clear of the two-cycle minimum after sync.
    task automatic half();
        repeat (8) @(posedge i_sys_clk);
        #1;
    endtask : half

    task automatic bit_io(input logic b, output logic r);
        o_sda_low = !b;
        half();
        o_scl = 1'b1;
        half();
        r = i_sda;
        o_scl = 1'b0;
        half();
    endtask : bit_io

    task automatic frame_start();
        o_sda_low = 1'b0;
        half();
        o_scl = 1'b1;
        half();
        o_sda_low = 1'b1;
        half();
        o_scl = 1'b0;
        half();
    endtask : frame_start

    task automatic frame_stop();
        o_sda_low = 1'b1;
        half();
        o_scl = 1'b1;
        half();
        o_sda_low = 1'b0;
        half();
    endtask : frame_stop

    task automatic byte_io(input logic [7:0] d, input logic ack_bit, output logic [7:0] q,
                           output logic acked);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(ack_bit, r);
        acked = !r;
    endtask : byte_io

    task automatic write_reg(input logic [6:0] dev, input logic [7:0] addr,
                             input logic [7:0] data, output logic ok);
        logic [7:0] q;
        logic       a0;
        logic       a1;
        logic       a2;
        frame_start();
        byte_io({dev, 1'b0}, 1'b1, q, a0);
        byte_io(addr, 1'b1, q, a1);
        byte_io(data, 1'b1, q, a2);
        frame_stop();
        ok = a0 & a1 & a2;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        logic [7:0] q;
        logic       a0;
        logic       a1;
        logic       a2;
        logic       a3;
        frame_start();
        byte_io({DEV_ADDR, 1'b0}, 1'b1, q, a0);
        byte_io(addr, 1'b1, q, a1);
        frame_start();
        byte_io({DEV_ADDR, 1'b1}, 1'b1, q, a2);
        byte_io(8'hFF, 1'b1, data, a3);
        frame_stop();
        ok = a0 & a1 & a2;
    endtask : read_reg
endmodule : jsr_host_model

// File: tb/tb.sv
module tb
    import jsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int P_REL = 2000;

    logic              sys_clk = 1'b0;
    logic              reset;
    logic              scl;
    logic              host_low;
    logic              sda_line;
    logic              sda_out;
    logic              sda_oe;
    logic              irq_n;
    logic              button_irq_enable;
    logic [7:0]        debounce_ticks;
    logic [7:0]        delay_ticks;
    logic [CODE_W-1:0] button_code;
    jsr_detect_t       detect;
    int                n_fail;
    int                n_tests;
    logic [7:0]        mask_bit [4] = '{8'h80, 8'h40, 8'h20, 8'h08};

    always #5 sys_clk = ~sys_clk;
    assign sda_line = (sda_oe ? sda_out : 1'b1) & !host_low;

    jsr_regs #(.P_RELEASE_CYCLES(P_REL)) u_jsr_regs (
        .i_sys_clk(sys_clk), .i_reset(reset), .i_scl(scl), .i_sda(sda_line),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_detect(detect),
        .i_debounce_ticks(debounce_ticks), .i_delay_ticks(delay_ticks),
        .i_button_irq_enable(button_irq_enable), .o_irq_n(irq_n), .o_button_code(button_code)
    );
    jsr_host_model u_jsr_host_model (
        .i_sys_clk(sys_clk), .i_sda(sda_line), .o_scl(scl), .o_sda_low(host_low)
    );

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : hold

    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        u_jsr_host_model.read_reg(addr, d, ok);
        check({7'h00, ok}, 8'h01);
        check(d, exp);
    endtask : rd

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic ok;
        u_jsr_host_model.write_reg(DEV_ADDR, addr, data, ok);
        check({7'h00, ok}, 8'h01);
    endtask : wr

    task automatic wait_irq(input int max);
        int n = 0;
        while (irq_n !== 1'b0 && n < max) begin
            hold(1);
            n++;
        end
        check({7'h00, irq_n}, 8'h00);
        if (irq_n !== 1'b0) begin
            end_of_test();
        end
    endtask : wait_irq

    initial begin
        n_fail = 0;
        n_tests = 0;
        reset = 1'b1;
        detect = '0;
        debounce_ticks = 8'h02;
        delay_ticks = 8'h02;
        button_irq_enable = 1'b0;
        hold(20);
        reset = 1'b0;
        hold(2);
        check({7'h00, irq_n}, 8'h00);
        hold(4 * P_REL);
        rd(ADDR_IRQ_EN_FIRST, IRQ_EN_RESET);
        rd(ADDR_SPARE_THREE, SPARE_RESET);
        for (int k = 0; k < 4; k++) begin
            detect.common_loc = k[1:0];
            rd(ADDR_RESET_COMMON, {4'h0, k == 0, 1'b0, k[1:0]});
            check({7'h00, irq_n}, 8'h01);
        end
        wr(ADDR_LOAD_BUTTON, 8'hF6);
        for (int i = 0; i < 4; i++) begin
            {detect.line_tip, detect.line_first_ring_contact, detect.tip_phone_load_seen,
             detect.first_ring_contact_phone_load_seen} = 4'h8 >> i;
            rd(ADDR_LOAD_BUTTON, {4'h8 >> i, 4'h0});
        end
        detect = '0;
        rd(8'h05, 8'h00);
        wr(ADDR_IRQ_EN_FIRST, 8'hEE);
        rd(ADDR_IRQ_EN_FIRST, 8'hEE);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_IRQ_EN_FIRST, mask_bit[i]);
            {detect.jack_found, detect.config_done, detect.slew_done, detect.mic_present} = 4'h8 >> i;
            hold(4);
            check({7'h00, irq_n}, 8'h00);
            {detect.jack_found, detect.config_done, detect.slew_done, detect.mic_present} = ~(4'h8 >> i);
            hold(4);
            check({7'h00, irq_n}, 8'h01);
        end
        detect = '0;
        wr(ADDR_IRQ_EN_FIRST, 8'h00);
        button_irq_enable = 1'b1;
        detect.button_raw_code = 8'h5A;
        detect.button_down = 1'b1;
        hold(5900);
        check({7'h00, irq_n}, 8'h01);
        wait_irq(4000);
        check(button_code, 8'h5A);
        rd(ADDR_LOAD_BUTTON, 8'h06);
        rd(ADDR_LOAD_BUTTON, 8'h02);
        check({7'h00, irq_n}, 8'h01);
        detect.button_down = 1'b0;
        wait_irq(10000);
        rd(ADDR_LOAD_BUTTON, 8'h06);
        hold(P_REL);
        rd(ADDR_LOAD_BUTTON, 8'h00);
        detect.sleep = 1'b1;
        detect.button_raw_code = 8'hA5;
        detect.button_down = 1'b1;
        wait_irq(10000);
        check(button_code, 8'hA5);
        rd(ADDR_LOAD_BUTTON, 8'h04);
        detect.sleep = 1'b0;
        button_irq_enable = 1'b0;
        wr(ADDR_IRQ_EN_FIRST, 8'h02);
        detect.bias_low = 1'b1;
        hold(5900);
        check({7'h00, irq_n}, 8'h01);
        wait_irq(4000);
        rd(ADDR_UPPER_STATUS, 8'h02);
        rd(ADDR_UPPER_STATUS, 8'h00);
        check({7'h00, irq_n}, 8'h01);
        detect.sleep = 1'b1;
        detect.bias_low = 1'b0;
        hold(4100);
        detect.bias_low = 1'b1;
        wait_irq(4100);
        rd(ADDR_UPPER_STATUS, 8'h02);
        rd(ADDR_LOAD_BUTTON, 8'h00);
        end_of_test();
    end
endmodule : tb
